//--- sme_pkg.sv
// Shared constants for the byte-wide serial engine.
// Assumes a single system clock; no bus, register strobes are plain ports.
package sme_pkg;

   // ****************************************
   // Control register field positions
   // ****************************************
   localparam int unsigned CTL_IRQ_EN = 7;
   localparam int unsigned CTL_PER_EN = 6;
   localparam int unsigned CTL_RATE2 = 5;
   localparam int unsigned CTL_MASTER = 4;
   localparam int unsigned CTL_CLOCK_IDLE_POLARITY = 3;
   localparam int unsigned CTL_CLOCK_CAPTURE_PHASE = 2;
   localparam int unsigned CTL_RATE1 = 1;
   localparam int unsigned CTL_RATE0 = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;

   // ****************************************
   // Control/status register field positions
   // ****************************************
   localparam int unsigned CSR_DONE = 7;
   localparam int unsigned CSR_WRITE_COLLISION_FLAG = 6;
   localparam int unsigned CSR_OVR = 5;
   localparam int unsigned CSR_MODE_FAULT_FLAG = 4;
   localparam int unsigned CSR_SOD = 2;
   localparam int unsigned CSR_SSM = 1;
   localparam int unsigned CSR_SSI = 0;
   localparam logic [2:0] CSR_CFG_RESET = 3'h0;

   // ****************************************
   // Baud selection {rate2,rate1,rate0} and half periods in clocks
   // ****************************************
   localparam logic [2:0] RATE_DIV4 = 3'h4;
   localparam logic [2:0] RATE_DIV8 = 3'h0;
   localparam logic [2:0] RATE_DIV16 = 3'h1;
   localparam logic [2:0] RATE_DIV32 = 3'h6;
   localparam logic [2:0] RATE_DIV64 = 3'h2;
   localparam logic [2:0] RATE_DIV128 = 3'h3;
   localparam logic [6:0] HALF_DIV4 = 7'h02;
   localparam logic [6:0] HALF_DIV8 = 7'h04;
   localparam logic [6:0] HALF_DIV16 = 7'h08;
   localparam logic [6:0] HALF_DIV32 = 7'h10;
   localparam logic [6:0] HALF_DIV64 = 7'h20;
   localparam logic [6:0] HALF_DIV128 = 7'h40;

   // ****************************************
   // Byte framing: 16 clock transitions per byte
   // ****************************************
   localparam logic [3:0] EDGE_FIRST = 4'h0;
   localparam logic [3:0] EDGE_LAST = 4'hF;

   typedef enum logic [1:0] {
      SME_IDLE = 2'b00,
      SME_MASTER = 2'b01
   } sme_state_t;

endpackage

//--- sme_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes the inputs are levels; the first stage feeds only the second.
`timescale 1ns/100ps
module sme_sync #(
   parameter int unsigned WIDTH = 4
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // Reset takes all ones (idle-high pins); low pins settle in two clocks
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_q <= '1;
         sync_out <= '1;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // sme_sync

//--- sme_baud.sv
// Half-period tick generator for the master serial clock.
// Assumes the half period is at least two clocks.
`timescale 1ns/100ps
module sme_baud #(
   parameter int unsigned CW = 7
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic run_in,
   input wire logic [CW-1:0] half_in,
   output logic tick_out
);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic wrap;

   assign wrap = (cnt_q == half_in - CW'(1));
   assign cnt_d = (!run_in || wrap) ? '0 : cnt_q + CW'(1);
   assign tick_out = run_in && wrap;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q <= '0;
      end else if (ce_in) begin
         cnt_q <= cnt_d;
      end
   end
endmodule // sme_baud

//--- sme_engine.sv
// Byte-wide serial engine, master or slave, with software register strobes.
// Assumes one 100 MHz clock; pins arrive asynchronously and are synchronised here.
`timescale 1ns/100ps
module sme_engine
   import sme_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic [7:0] wdata_in,
   input wire logic ctrl_wr_in,
   input wire logic csr_rd_in,
   input wire logic csr_wr_in,
   input wire logic dr_rd_in,
   input wire logic dr_wr_in,
   input wire logic cpu_irq_mask_in,
   input wire logic sck_in,
   input wire logic mosi_in,
   input wire logic miso_in,
   input wire logic ss_n_in,
   output logic [7:0] ctrl_rdata_out,
   output logic [7:0] csr_rdata_out,
   output logic [7:0] dr_rdata_out,
   output logic irq_out,
   output logic sck_out,
   output logic sck_oe_out,
   output logic mosi_out,
   output logic mosi_oe_out,
   output logic miso_out,
   output logic miso_oe_out
);
   // ****************************************
   // Storage
   // ****************************************
   sme_state_t state_q;
   logic [7:0] ctrl_q, ctrl_d;
   logic [2:0] cfg_q;
   logic [7:0] tx_q, rx_q, rxbuf_q;
   logic [3:0] edge_q;
   logic sck_q, sck_prev_q;
   logic transfer_done_flag_q, transfer_done_flag_seq_q, transfer_done_flag_rd_q;
   logic ovr_q, write_collision_flag_q, write_collision_flag_seq_q, mode_fault_flag_q, mode_fault_flag_seq_q;
   logic sck_oe_q, mosi_oe_q, miso_oe_q, irq_q;
   logic [7:0] csr_q;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [3:0] pins_s;
   logic ss_s, sck_s, mosi_s, miso_s;

   sme_sync #(.WIDTH(4)) u_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .async_in({ss_n_in, sck_in, mosi_in, miso_in}),
      .sync_out(pins_s)
   );
   assign {ss_s, sck_s, mosi_s, miso_s} = pins_s;

   // ****************************************
   // Decode
   // ****************************************
   logic is_master, per_en, clock_idle_polarity, clock_capture_phase, ss_int, fault_set, slave_act;
   logic busy, sck_edge, master_tick, edge_go, din, capture, shift_ok, done;
   logic [2:0] rate;
   logic [6:0] half;
   logic [7:0] rx_next;
   logic csr_acc, dr_acc, transfer_done_flag_clr, wr_ok, wr_take, start, buf_load;
   logic ovr_set, write_collision_flag_set, write_collision_flag_clr, mode_fault_flag_clr, mode_fault_flag_lock;

   assign is_master = ctrl_q[CTL_MASTER];
   assign per_en = ctrl_q[CTL_PER_EN];
   assign clock_idle_polarity = ctrl_q[CTL_CLOCK_IDLE_POLARITY];
   assign clock_capture_phase = ctrl_q[CTL_CLOCK_CAPTURE_PHASE];
   assign rate = {ctrl_q[CTL_RATE2], ctrl_q[CTL_RATE1], ctrl_q[CTL_RATE0]};
   assign ss_int = cfg_q[CSR_SSM] ? cfg_q[CSR_SSI] : ss_s;
   assign fault_set = is_master && !ss_int;
   assign slave_act = per_en && !is_master && !ss_int;

   // Undefined rate codes fall back to the fastest divider
   assign half = (rate == RATE_DIV8) ? HALF_DIV8 :
                 (rate == RATE_DIV16) ? HALF_DIV16 :
                 (rate == RATE_DIV32) ? HALF_DIV32 :
                 (rate == RATE_DIV64) ? HALF_DIV64 :
                 (rate == RATE_DIV128) ? HALF_DIV128 : HALF_DIV4;

   sme_baud #(.CW(7)) u_baud (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .run_in(state_q == SME_MASTER),
      .half_in(half),
      .tick_out(master_tick)
   );

   assign sck_edge = sck_s ^ sck_prev_q;
   assign edge_go = (state_q == SME_MASTER) ? master_tick : (slave_act && sck_edge);
   assign din = is_master ? miso_s : mosi_s;
   assign capture = (edge_q[0] == clock_capture_phase);
   assign shift_ok = !capture && !(clock_capture_phase && edge_q == EDGE_FIRST);
   assign rx_next = capture ? {rx_q[6:0], din} : rx_q;
   assign done = edge_go && (edge_q == EDGE_LAST);
   assign busy = (state_q == SME_MASTER) || (slave_act && edge_q != EDGE_FIRST);

   // Flag sequencing
   assign csr_acc = csr_rd_in || csr_wr_in;
   assign dr_acc = dr_rd_in || dr_wr_in;
   assign transfer_done_flag_clr = transfer_done_flag_seq_q && dr_acc;
   assign wr_ok = dr_wr_in && !(transfer_done_flag_q && !transfer_done_flag_rd_q);
   assign write_collision_flag_set = dr_wr_in && busy;
   assign wr_take = wr_ok && !busy;
   assign start = wr_take && is_master && per_en && !fault_set;
   assign ovr_set = done && transfer_done_flag_q && !transfer_done_flag_clr;
   assign buf_load = done && !ovr_set;
   assign write_collision_flag_clr = write_collision_flag_seq_q && dr_rd_in;
   assign mode_fault_flag_clr = mode_fault_flag_seq_q && ctrl_wr_in;
   assign mode_fault_flag_lock = mode_fault_flag_q && !mode_fault_flag_seq_q;

   // ****************************************
   // Control register next value
   // ****************************************
   always_comb begin
      ctrl_d = ctrl_q;
      if (ctrl_wr_in) begin
         ctrl_d = wdata_in;
         if (mode_fault_flag_lock) begin
            ctrl_d[CTL_PER_EN] = wdata_in[CTL_PER_EN] & ctrl_q[CTL_PER_EN];
            ctrl_d[CTL_MASTER] = wdata_in[CTL_MASTER] & ctrl_q[CTL_MASTER];
         end
      end
      if (fault_set) begin
         ctrl_d[CTL_PER_EN] = 1'b0;
         ctrl_d[CTL_MASTER] = 1'b0;
      end
   end

   // ****************************************
   // Registers and flags
   // ****************************************
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q <= CTL_RESET;
         cfg_q <= CSR_CFG_RESET;
         transfer_done_flag_q <= 1'b0;
         transfer_done_flag_seq_q <= 1'b0;
         transfer_done_flag_rd_q <= 1'b0;
         ovr_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         write_collision_flag_seq_q <= 1'b0;
         mode_fault_flag_q <= 1'b0;
         mode_fault_flag_seq_q <= 1'b0;
         rxbuf_q <= 8'h00;
      end else if (ce_in) begin
         ctrl_q <= ctrl_d;
         if (csr_wr_in) begin
            cfg_q <= {wdata_in[CSR_SOD], wdata_in[CSR_SSM], wdata_in[CSR_SSI]};
         end
         transfer_done_flag_q <= done || (transfer_done_flag_q && !transfer_done_flag_clr);
         transfer_done_flag_seq_q <= (transfer_done_flag_seq_q || (csr_acc && transfer_done_flag_q)) && !transfer_done_flag_clr;
         transfer_done_flag_rd_q <= (transfer_done_flag_rd_q || (csr_rd_in && transfer_done_flag_q)) && !transfer_done_flag_clr;
         ovr_q <= ovr_set || (ovr_q && !csr_rd_in);
         write_collision_flag_q <= write_collision_flag_set || (write_collision_flag_q && !write_collision_flag_clr);
         write_collision_flag_seq_q <= (write_collision_flag_seq_q || (csr_rd_in && write_collision_flag_q)) && !write_collision_flag_clr;
         mode_fault_flag_q <= fault_set || (mode_fault_flag_q && !mode_fault_flag_clr);
         mode_fault_flag_seq_q <= (mode_fault_flag_seq_q || (csr_rd_in && mode_fault_flag_q)) && !mode_fault_flag_clr;
         if (buf_load) begin
            rxbuf_q <= rx_next;
         end
      end
   end

   // ****************************************
   // Shift engine
   // ****************************************
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= SME_IDLE;
         tx_q <= 8'h00;
         rx_q <= 8'h00;
         edge_q <= EDGE_FIRST;
         sck_q <= 1'b0;
         // Matches the synchroniser reset level so no false edge follows reset
         sck_prev_q <= 1'b1;
      end else if (ce_in) begin
         sck_prev_q <= sck_s;
         unique case (state_q)
            SME_IDLE: begin
               sck_q <= clock_idle_polarity;
               if (!slave_act) begin
                  edge_q <= EDGE_FIRST;
               end
               if (start) begin
                  state_q <= SME_MASTER;
                  edge_q <= EDGE_FIRST;
               end
            end
            SME_MASTER: begin
               if (fault_set) begin
                  state_q <= SME_IDLE;
               end else if (master_tick) begin
                  sck_q <= !sck_q;
                  if (done) begin
                     state_q <= SME_IDLE;
                  end
               end
            end
         endcase
         if (wr_take) begin
            tx_q <= wdata_in;
         end else if (edge_go) begin
            edge_q <= edge_q + 4'h1;
            rx_q <= rx_next;
            if (shift_ok) begin
               tx_q <= {tx_q[6:0], 1'b0};
            end
         end
      end
   end

   // ****************************************
   // Output flops
   // ****************************************
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sck_oe_q <= 1'b0;
         mosi_oe_q <= 1'b0;
         miso_oe_q <= 1'b0;
         irq_q <= 1'b0;
         csr_q <= 8'h00;
      end else if (ce_in) begin
         sck_oe_q <= per_en && is_master;
         mosi_oe_q <= per_en && is_master && !cfg_q[CSR_SOD];
         miso_oe_q <= slave_act && !cfg_q[CSR_SOD];
         irq_q <= ctrl_q[CTL_IRQ_EN] && !cpu_irq_mask_in && (transfer_done_flag_q || ovr_q || mode_fault_flag_q);
         csr_q <= {transfer_done_flag_q, write_collision_flag_q, ovr_q, mode_fault_flag_q, 1'b0, cfg_q};
      end
   end

   assign ctrl_rdata_out = ctrl_q;
   assign csr_rdata_out = csr_q;
   assign dr_rdata_out = rxbuf_q;
   assign irq_out = irq_q;
   assign sck_out = sck_q;
   assign sck_oe_out = sck_oe_q;
   assign mosi_out = tx_q[7];
   assign mosi_oe_out = mosi_oe_q;
   assign miso_out = tx_q[7];
   assign miso_oe_out = miso_oe_q;

   // ****************************************
   // Checks
   // ****************************************
   chk_fault_drops_mode: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && fault_set |=> mode_fault_flag_q && !ctrl_q[CTL_MASTER] && !ctrl_q[CTL_PER_EN])
      else $error("mode fault did not drop master and enable");
   chk_no_slave_fault: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && !ctrl_q[CTL_MASTER] |=> !$rose(mode_fault_flag_q))
      else $error("mode fault rose while slave");
   chk_done_sets_flag: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && done |=> transfer_done_flag_q)
      else $error("done flag not set at byte end");
   chk_irq_needs_enable: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && (!ctrl_q[CTL_IRQ_EN] || cpu_irq_mask_in) |=> !irq_q)
      else $error("interrupt raised while disabled");
   chk_write_collision_flag_no_irq: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && !transfer_done_flag_q && !ovr_q && !mode_fault_flag_q |=> !irq_q)
      else $error("collision alone raised interrupt");
   chk_ovr_keeps_buf: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && ovr_set |=> ovr_q && $stable(rxbuf_q))
      else $error("overrun changed receive buffer");
   chk_busy_write_write_collision_flag: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && dr_wr_in && busy |=> write_collision_flag_q)
      else $error("collision not flagged");
   chk_ovr_read_clear: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && csr_rd_in && !ovr_set |=> !ovr_q)
      else $error("overrun not cleared by status read");
   chk_master_start: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && start |=> state_q == SME_MASTER && edge_q == EDGE_FIRST && tx_q == $past(wdata_in))
      else $error("master start did not load byte");
   chk_lock_blocks_enable: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && mode_fault_flag_lock && !ctrl_q[CTL_PER_EN] |=> !ctrl_q[CTL_PER_EN])
      else $error("enable set while fault locked");
   chk_write_collision_flag_write_keeps: assert property (@(posedge clk_in) disable iff (rst_in)
      ce_in && write_collision_flag_q && !dr_rd_in |=> write_collision_flag_q)
      else $error("collision flag cleared without data read");
endmodule // sme_engine

//--- sme_peer.sv
// Far-side model: a serial slave for master tests, a serial master for slave tests.
// Assumes the bench clears edges and loads tx_q before each master-mode byte.
`timescale 1ns/100ps
module sme_peer (
   input wire logic clk_in,
   input wire logic dsck_in,
   input wire logic mosi_in,
   input wire logic miso_in,
   input wire logic clock_idle_polarity_in,
   output logic miso_out,
   output logic sck_out,
   output logic mosi_out
);
   logic [7:0] tx_q;
   logic [7:0] rx_q;
   int edges;
   int span;
   time t0;

   initial begin
      sck_out = 1'b0;
      mosi_out = 1'b1;
      tx_q = 8'h00;
      rx_q = 8'h00;
      edges = 0;
   end

   // ****************************************
   // Slave role, phase 0: capture on leading edge, shift on trailing
   // ****************************************
   always @(dsck_in) begin
      edges = edges + 1;
      if (edges == 1) t0 = $time;
      span = int'(($time - t0) / 10);
      if (dsck_in !== clock_idle_polarity_in) rx_q = {rx_q[6:0], mosi_in};
      else tx_q = {tx_q[6:0], ~tx_q[7]};
   end
   assign miso_out = tx_q[7];

   // ****************************************
   // Master role, polarity 0 phase 1, 8 clocks high and 9 clocks low per bit
   // ****************************************
   task automatic send(input logic [7:0] b, output logic [7:0] got);
      for (int k = 7; k >= 0; k--) begin
         @(posedge clk_in) sck_out <= 1'b1;
         mosi_out <= b[k];
         repeat (8) @(posedge clk_in);
         got[k] = miso_in;
         sck_out <= 1'b0;
         repeat (8) @(posedge clk_in);
      end
      mosi_out <= ~b[0];
   endtask
endmodule // sme_peer

//--- tb.sv
// Self-checking bench for the serial engine, driving its register strobes.
// Assumes sme_engine, sme_peer and sme_pkg are compiled first.
`timescale 1ns/100ps
module tb;
   import sme_pkg::*;
   logic clk_in, rst_in, ce_in, ctrl_wr, csr_rd, csr_wr, dr_rd, dr_wr, mask, ss_n;
   logic [7:0] wdata, ctrl_q, csr_q, dr_q, cfg, got;
   logic irq, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, p_miso, p_sck, p_mosi;
   logic [2:0] rates [6] = '{RATE_DIV4, RATE_DIV8, RATE_DIV16, RATE_DIV32, RATE_DIV64,
      RATE_DIV128};
   logic [6:0] halves [6] = '{HALF_DIV4, HALF_DIV8, HALF_DIV16, HALF_DIV32, HALF_DIV64,
      HALF_DIV128};
   int err_count = 0;
   int n_compared = 0;
   int i;

   sme_engine dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .wdata_in(wdata),
      .ctrl_wr_in(ctrl_wr), .csr_rd_in(csr_rd), .csr_wr_in(csr_wr), .dr_rd_in(dr_rd),
      .dr_wr_in(dr_wr), .cpu_irq_mask_in(mask), .sck_in(p_sck), .mosi_in(p_mosi),
      .miso_in(p_miso), .ss_n_in(ss_n), .ctrl_rdata_out(ctrl_q), .csr_rdata_out(csr_q),
      .dr_rdata_out(dr_q), .irq_out(irq), .sck_out(sck), .sck_oe_out(sck_oe),
      .mosi_out(mosi), .mosi_oe_out(mosi_oe), .miso_out(miso), .miso_oe_out(miso_oe));
   sme_peer peer (.clk_in(clk_in), .dsck_in(sck), .mosi_in(mosi), .miso_in(miso),
      .clock_idle_polarity_in(ctrl_q[CTL_CLOCK_IDLE_POLARITY]), .miso_out(p_miso), .sck_out(p_sck), .mosi_out(p_mosi));

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Strobe codes: 0 ctrl write, 1 csr write, 2 data write, 3 csr read, 4 data read
   task automatic pulse(input int k, input logic [7:0] d);
      @(posedge clk_in);
      wdata <= d;
      {ctrl_wr, csr_wr, dr_wr, csr_rd, dr_rd} <= 5'h10 >> k;
      @(posedge clk_in);
      {ctrl_wr, csr_wr, dr_wr, csr_rd, dr_rd} <= 5'h00;
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wait_done;
      for (int k = 0; k < 3000 && csr_q[CSR_DONE] !== 1'b1; k++) tk(1);
      chk(csr_q[CSR_DONE], 1'b1);
   endtask
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #1_000_000;
      err_count++;
      final_report;
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      {ctrl_wr, csr_wr, dr_wr, csr_rd, dr_rd} = 5'h00;
      wdata = 8'h00;
      mask = 1'b0;
      ss_n = 1'b1;
      ce_in = 1'b1;
      rst_in = 1'b1;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      tk(3);
      chk({ctrl_q, csr_q}, 16'h0000);
      chk({dr_q, 7'h00, irq}, 16'h0000);
      for (i = 0; i < 6; i++) begin
         cfg = {2'b10, rates[i][2], 1'b0, i[0], 1'b0, rates[i][1:0]};
         @(posedge clk_in) mask <= i[1];
         pulse(0, cfg);
         pulse(1, 8'h00);
         pulse(0, cfg | 8'h50);
         tk(3);
         chk(ctrl_q, cfg | 8'h50);
         chk(sck, i[0]);
         chk({sck_oe, mosi_oe, miso_oe}, 3'b110);
         peer.edges = 0;
         peer.tx_q = 8'h3C;
         pulse(2, 8'hA5 ^ i[7:0]);
         wait_done;
         chk(peer.edges[15:0], 16'd16);
         chk(peer.span[15:0], 16'd15 * halves[i]);
         chk(peer.rx_q, 8'hA5 ^ i[7:0]);
         if (i > 1) chk(dr_q, 8'h3C);
         tk(2);
         chk(irq, !i[1]);
         pulse(3, 8'h00);
         pulse(4, 8'h00);
         tk(3);
         chk(csr_q[CSR_DONE], 1'b0);
      end
      peer.edges = 0;
      pulse(2, 8'h81);
      tk(20);
      pulse(2, 8'hFF);
      tk(3);
      chk(csr_q & 8'hC0, 8'h40);
      chk(irq, 1'b0);
      wait_done;
      chk(peer.rx_q, 8'h81);
      pulse(2, 8'h11);
      tk(100);
      chk(peer.edges[15:0], 16'd16);
      pulse(3, 8'h00);
      pulse(2, 8'h22);
      tk(3);
      chk(csr_q & 8'hC0, 8'h40);
      wait_done;
      chk(peer.rx_q, 8'h22);
      pulse(3, 8'h00);
      pulse(4, 8'h00);
      tk(3);
      chk(csr_q & 8'hC0, 8'h00);
      pulse(1, 8'h03);
      @(posedge clk_in) ss_n <= 1'b0;
      tk(10);
      chk({csr_q & 8'h10, ctrl_q & 8'h50}, 16'h0050);
      pulse(1, 8'h00);
      tk(6);
      chk({csr_q & 8'h10, ctrl_q & 8'h50}, 16'h1000);
      chk(irq, 1'b1);
      @(posedge clk_in) ss_n <= 1'b1;
      tk(4);
      pulse(0, cfg | 8'h50);
      tk(3);
      chk({csr_q & 8'h10, ctrl_q & 8'h50}, 16'h1000);
      pulse(3, 8'h00);
      pulse(0, cfg | 8'h50);
      tk(3);
      chk({csr_q & 8'h10, ctrl_q & 8'h50}, 16'h0050);
      pulse(0, 8'h04);
      pulse(0, 8'h44);
      pulse(2, 8'hC3);
      @(posedge clk_in) ss_n <= 1'b0;
      tk(20);
      chk(csr_q[CSR_DONE], 1'b0);
      chk({sck_oe, mosi_oe, miso_oe}, 3'b001);
      peer.send(8'h5A, got);
      chk(got, 8'hC3);
      tk(8);
      chk(dr_q, 8'h5A);
      chk(csr_q & 8'h90, 8'h80);
      peer.send(8'h96, got);
      tk(8);
      chk({csr_q & 8'hA0, dr_q}, 16'hA05A);
      pulse(3, 8'h00);
      tk(3);
      chk(csr_q[CSR_OVR], 1'b0);
      @(posedge clk_in) ss_n <= 1'b1;
      tk(2);
      final_report;
   end
endmodule // tb
